// ===== logic/gpp_pkg.sv
// Constants for the eight-pin general-purpose port: offsets, resets, codes.
// Assumes byte addresses on a twelve-bit register port with 32-bit data.
package gpp_pkg;
  // ==========================================
  // Register offsets
  localparam logic [11:0] OFS_DIR = 12'h400;
  localparam logic [11:0] OFS_SENSE = 12'h404;
  localparam logic [11:0] OFS_BOTH = 12'h408;
  localparam logic [11:0] OFS_EVENT = 12'h40C;
  localparam logic [11:0] OFS_MASK = 12'h410;
  localparam logic [11:0] OFS_RAW = 12'h414;
  localparam logic [11:0] OFS_MSTAT = 12'h418;
  localparam logic [11:0] OFS_CLEAR = 12'h41C;
  localparam logic [11:0] OFS_AFSEL = 12'h420;
  localparam logic [11:0] OFS_DR2 = 12'h500;
  localparam logic [11:0] OFS_DR4 = 12'h504;
  localparam logic [11:0] OFS_DR8 = 12'h508;
  localparam logic [11:0] OFS_ODR = 12'h50C;
  localparam logic [11:0] OFS_PUR = 12'h510;
  localparam logic [11:0] OFS_PDR = 12'h514;
  localparam logic [11:0] OFS_SLR = 12'h518;
  localparam logic [11:0] OFS_DEN = 12'h51C;
  localparam logic [11:0] OFS_LOCK = 12'h520;
  localparam logic [11:0] OFS_COMMIT = 12'h524;
  localparam logic [11:0] OFS_ID_LO = 12'hFD0;
  // ==========================================
  // Field positions
  localparam int DMASK_MSB = 9;
  localparam int DMASK_LSB = 2;
  localparam int ADC_PIN = 4;
  localparam logic [3:0] ID_IDX_BASE = 4'h4;
  // ==========================================
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DR2 = 8'hFF;
  // Unlock key; the value is arbitrary.
  localparam logic [31:0] LOCK_KEY = 32'h5A5A0F0F;
  // Identification words; the values are arbitrary.
  localparam logic [7:0] ID_WORDS [12] = '{
    8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66,
    8'h77, 8'h88, 8'h99, 8'hAA, 8'hBB, 8'hCC};
  // ==========================================
  // Lock states
  typedef enum logic {
    GPP_UNLOCKED = 1'b0,
    GPP_LOCKED = 1'b1
  } gpp_lock_e;
endpackage

// ===== logic/gpp_irq_detect.sv
// Per-pin trigger detection and raw interrupt status for eight pins.
// Assumes sampled pin levels and one-cycle clear pulses from the port.
`timescale 1ns/1ns
`default_nettype none
module gpp_irq_detect
  import gpp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pin levels and trigger selects
  input wire logic [7:0] pin,
  input wire logic [7:0] sense,
  input wire logic [7:0] both,
  input wire logic [7:0] event_hi,
  // Clear pulses and status
  input wire logic [7:0] clr,
  output logic [7:0] raw
);
  logic [7:0] prev;
  logic [7:0] next_raw;
  wire [7:0] rise = pin & ~prev;
  wire [7:0] fall = ~pin & prev;
  wire [7:0] level_hit = (pin & event_hi) | (~pin & ~event_hi);

  // ==========================================
  // Trigger selection per pin
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_pin
      wire edge_hit = both[i] ? (rise[i] | fall[i])
                              : (event_hi[i] ? rise[i] : fall[i]);
      assign next_raw[i] = sense[i] ? level_hit[i]
                                    : (edge_hit | (raw[i] & ~clr[i]));
    end
  endgenerate

  // ==========================================
  // Status storage
  // previous pin level and raw status
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      prev <= RST_ZERO;
      raw <= RST_ZERO;
    end
    else
    begin
      prev <= pin;
      raw <= next_raw;
    end
  end
endmodule
`default_nettype wire

// ===== logic/gpp_port.sv
// One eight-pin general-purpose port with its register file and pad control.
// Assumes pins synchronous to core_clk and a one-cycle register strobe port.
// Operation
// - After reset pins are undriven; function, enable and pull bits zero.
// - Protected debug pins reset with function, enable and pull-up set.
// - Power-on or external reset restores both pin groups to defaults.
// - Direction zero makes an input; data bit holds the sampled level.
// - Direction one makes an output driving the data bit.
// - Data accesses use address bits nine to two as a pin mask.
// - The data register spans 256 word aliases, one per mask.
// - Data writes change only bits whose mask bit is one.
// - Data reads return zero on bits whose mask bit is zero.
// - All pin interrupts merge into one request line.
// - Edge interrupts stay latched until software clears them.
// - Sense, both-edges and event selects choose each pin's trigger.
// - Mask bits gate each pin onto the merged request.
// - Raw status ignores the mask; masked status shows enabled flags.
// - An unmasked converter-trigger pin interrupt pulses the trigger out.
// - Writing one to a clear bit clears that latch; zero does nothing.
// - With alternate function set the peripheral owns the pin.
// - Protected function bits change only when unlocked and committed.
// - Pad strength, drain, pulls, slew and enable come from registers.
// - Twelve read-only identification words return fixed values.
`timescale 1ns/1ns
`default_nettype none
module gpp_port
  import gpp_pkg::*;
#(
  parameter logic [7:0] PROT_MASK = 8'h00,
  parameter logic ADC_TAP = 1'b0
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Pads
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  // Pad configuration
  output logic [7:0] pad_dr2,
  output logic [7:0] pad_dr4,
  output logic [7:0] pad_dr8,
  output logic [7:0] pad_odr,
  output logic [7:0] pad_pu,
  output logic [7:0] pad_pd,
  output logic [7:0] pad_slew,
  output logic [7:0] pad_den,
  // Peripheral side
  input wire logic [7:0] alt_out,
  input wire logic [7:0] alt_oe,
  output logic [7:0] alt_in,
  // Interrupt and converter trigger
  output logic irq,
  output logic adc_trig
);
  logic [7:0] pin_data;
  logic [7:0] dir;
  logic [7:0] sense;
  logic [7:0] both;
  logic [7:0] event_hi;
  logic [7:0] im;
  logic [7:0] afsel;
  logic [7:0] commit;
  logic [7:0] in_q;
  logic [7:0] raw;
  logic mis_adc_q;
  gpp_lock_e lock_st;

  // ==========================================
  // Address decode
  // data aliases
  wire data_sel = (addr[11:10] == 2'b00);
  wire [7:0] dmask = addr[DMASK_MSB:DMASK_LSB];
  wire id_sel = (addr >= OFS_ID_LO);
  wire [3:0] id_idx = addr[5:2] - ID_IDX_BASE;
  wire w_data = wr && data_sel;
  wire w_dir = wr && (addr == OFS_DIR);
  wire w_sense = wr && (addr == OFS_SENSE);
  wire w_both = wr && (addr == OFS_BOTH);
  wire w_event = wr && (addr == OFS_EVENT);
  wire w_mask = wr && (addr == OFS_MASK);
  wire w_clear = wr && (addr == OFS_CLEAR);
  wire w_afsel = wr && (addr == OFS_AFSEL);
  wire w_lock = wr && (addr == OFS_LOCK);
  wire w_commit = wr && (addr == OFS_COMMIT);
  wire unlocked = (lock_st == GPP_UNLOCKED);
  wire [7:0] wd = wdata[7:0];

  // ==========================================
  // Next values
  // masked write
  wire [7:0] wr_data = w_data ? ((wd & dmask) | (pin_data & ~dmask)) : pin_data;
  wire [7:0] next_data = (wr_data & dir) | (in_q & ~dir);
  wire [7:0] af_wmask = commit & (unlocked ? 8'hFF : ~PROT_MASK);
  wire [7:0] next_afsel = (wd & af_wmask) | (afsel & ~af_wmask);
  wire [7:0] next_commit = (wd & PROT_MASK) | ~PROT_MASK;
  wire [7:0] clr = w_clear ? wd : RST_ZERO;
  wire [7:0] mis = raw & im;
  wire [7:0] src_out = (afsel & alt_out) | (~afsel & pin_data);
  wire [7:0] src_oe = (afsel & alt_oe) | (~afsel & dir);
  wire [7:0] next_oe = pad_den & src_oe & ~(pad_odr & src_out);
  wire [7:0] next_out = src_out & ~pad_odr;

  // ==========================================
  // Read selection
  // masked read
  wire [7:0] rd_data = pin_data & dmask;
  wire [7:0] rd_id = (id_idx < 4'd12) ? ID_WORDS[id_idx] : RST_ZERO;
  wire [7:0] rd_mux =
    data_sel ? rd_data :
    id_sel ? rd_id :
    (addr == OFS_DIR) ? dir :
    (addr == OFS_SENSE) ? sense :
    (addr == OFS_BOTH) ? both :
    (addr == OFS_EVENT) ? event_hi :
    (addr == OFS_MASK) ? im :
    (addr == OFS_RAW) ? raw :
    (addr == OFS_MSTAT) ? mis :
    (addr == OFS_AFSEL) ? afsel :
    (addr == OFS_DR2) ? pad_dr2 :
    (addr == OFS_DR4) ? pad_dr4 :
    (addr == OFS_DR8) ? pad_dr8 :
    (addr == OFS_ODR) ? pad_odr :
    (addr == OFS_PUR) ? pad_pu :
    (addr == OFS_PDR) ? pad_pd :
    (addr == OFS_SLR) ? pad_slew :
    (addr == OFS_DEN) ? pad_den :
    (addr == OFS_LOCK) ? {7'h00, lock_st} :
    (addr == OFS_COMMIT) ? commit : RST_ZERO;

  // ==========================================
  // Data, direction and interrupt registers
  // reset defaults
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pin_data <= RST_ZERO;
      dir <= RST_ZERO;
      sense <= RST_ZERO;
      both <= RST_ZERO;
      event_hi <= RST_ZERO;
      im <= RST_ZERO;
      in_q <= RST_ZERO;
    end
    else
    begin
      pin_data <= next_data;
      in_q <= pad_in & pad_den;
      if (w_dir)
        dir <= wd;
      if (w_sense)
        sense <= wd;
      if (w_both)
        both <= wd;
      if (w_event)
        event_hi <= wd;
      if (w_mask)
        im <= wd;
    end
  end

  // ==========================================
  // Mode, commit and lock registers
  // debug pin defaults
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      afsel <= PROT_MASK;
      commit <= ~PROT_MASK;
      lock_st <= GPP_LOCKED;
    end
    else
    begin
      if (w_afsel)
        afsel <= next_afsel;
      if (w_commit && unlocked)
        commit <= next_commit;
      if (w_lock)
        lock_st <= (wdata == LOCK_KEY) ? GPP_UNLOCKED : GPP_LOCKED;
    end
  end

  // ==========================================
  // Pad configuration registers
  // pad settings
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pad_dr2 <= RST_DR2;
      pad_dr4 <= RST_ZERO;
      pad_dr8 <= RST_ZERO;
      pad_odr <= RST_ZERO;
      pad_pu <= PROT_MASK;
      pad_pd <= RST_ZERO;
      pad_slew <= RST_ZERO;
      pad_den <= PROT_MASK;
    end
    else if (wr)
    begin
      if (addr == OFS_DR2)
        pad_dr2 <= wd;
      if (addr == OFS_DR4)
        pad_dr4 <= wd;
      if (addr == OFS_DR8)
        pad_dr8 <= wd;
      if (addr == OFS_ODR)
        pad_odr <= wd;
      if (addr == OFS_PUR)
        pad_pu <= wd;
      if (addr == OFS_PDR)
        pad_pd <= wd;
      if (addr == OFS_SLR)
        pad_slew <= wd;
      if (addr == OFS_DEN)
        pad_den <= wd;
    end
  end

  // ==========================================
  // Pads, read data, interrupt and trigger outputs
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pad_out <= RST_ZERO;
      pad_oe <= RST_ZERO;
      alt_in <= RST_ZERO;
      rdata <= 32'h00000000;
      irq <= 1'b0;
      adc_trig <= 1'b0;
      mis_adc_q <= 1'b0;
    end
    else
    begin
      pad_out <= next_out;
      pad_oe <= next_oe;
      alt_in <= in_q & afsel;
      rdata <= rd ? {24'h000000, rd_mux} : 32'h00000000;
      irq <= |mis;
      mis_adc_q <= mis[ADC_PIN];
      adc_trig <= ADC_TAP && mis[ADC_PIN] && !mis_adc_q;
    end
  end

  // ==========================================
  // Trigger detection
  // raw status, no mask gating
  gpp_irq_detect u_detect (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(in_q),
    .sense(sense),
    .both(both),
    .event_hi(event_hi),
    .clr(clr),
    .raw(raw)
  );

  // ==========================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_data_wr;
    w_data;
  endsequence
  sequence s_locked_af_wr;
    w_afsel && !unlocked;
  endsequence

  data_write_a:
  assert property (s_data_wr |=>
    ((pin_data ^ $past(wd)) & $past(dmask) & $past(dir)) == 8'h00)
    else $error("masked data write lost");
  data_keep_a:
  assert property (s_data_wr |=>
    ((pin_data ^ $past(pin_data)) & ~$past(dmask) & $past(dir)) == 8'h00)
    else $error("unmasked data bit changed");
  data_read_a:
  assert property (rd && data_sel |=>
    rdata == {24'h000000, $past(pin_data) & $past(dmask)})
    else $error("masked data read wrong");
  input_hold_a:
  assert property (1'b1 |=> ((pin_data ^ $past(in_q)) & ~$past(dir)) == 8'h00)
    else $error("input bit not captured");
  irq_merge_a:
  assert property (##1 irq == |($past(raw) & $past(im)))
    else $error("merged request wrong");
  edge_latch_a:
  assert property (1'b1 |=>
    ($past(raw) & ~raw & ~$past(sense) & ~$past(clr)) == 8'h00)
    else $error("edge latch dropped");
  clear_one_a:
  assert property (w_clear && in_q == $past(in_q)
    |=> (raw & $past(wd) & ~$past(sense)) == 8'h00)
    else $error("clear did not act");
  af_protect_a:
  assert property (s_locked_af_wr |=> ((afsel ^ $past(afsel)) & PROT_MASK) == 8'h00)
    else $error("protected bit changed while locked");
  alt_own_a:
  assert property (##1 ((pad_oe ^ $past(alt_oe)) &
    $past(afsel & pad_den & ~pad_odr)) == 8'h00)
    else $error("peripheral enable not passed");
  gpio_drive_a:
  assert property (##1 (pad_oe & ~$past(afsel) & ~$past(dir)) == 8'h00)
    else $error("input pin driven");
  adc_pulse_a:
  assert property (adc_trig |-> ADC_TAP ##1 !adc_trig)
    else $error("trigger not a single pulse");
  open_drain_a:
  assert property (##1
    ((pad_out | (pad_oe & $past(src_out))) & $past(pad_odr)) == 8'h00)
    else $error("open-drain pin driven high");
  level_follow_a:
  assert property (##1 ((raw ^ $past(in_q ~^ event_hi)) & $past(sense)) == 8'h00)
    else $error("level status does not follow pin");
endmodule
`default_nettype wire

// ===== tb/gpp_pin_model.sv
// Pin model: external drivers and pull resistors seen by the eight pads.
// Assumes the bench changes ext_val and ext_en just after clock edges.
`timescale 1ns/1ns
`default_nettype none
module gpp_pin_model
(
  // Clock
  input wire logic core_clk,
  // Pad side
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pu,
  input wire logic [7:0] pad_pd,
  output logic [7:0] pad_in,
  // Bench commands
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en
);
  logic [7:0] float_q = 8'h00;
  // ==========================
  // Wire level
  // Floating lines without a pull change every cycle.
  always @(posedge core_clk)
    float_q <= ~float_q;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
    | (~pad_oe & ~ext_en & (pad_pu | (~pad_pd & float_q)));
endmodule
`default_nettype wire

// ===== tb/gpp_port_tb.sv
// Bench for the eight-pin port: register port, pads, interrupts, protection.
// Assumes the pin model on the pads and the port set up as a port B.
`timescale 1ns/1ns
`default_nettype none
module gpp_port_tb;
  import gpp_pkg::*;
  localparam logic [11:0] PAD_OFS [7] = '{OFS_DR2, OFS_DR4, OFS_DR8, OFS_ODR, OFS_PDR,
    OFS_SLR, OFS_PUR};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [7:0] pad_in, pad_out, pad_oe, pad_dr2, pad_dr4, pad_dr8, pad_odr;
  logic [7:0] pad_pu, pad_pd, pad_slew, pad_den, alt_in;
  logic [7:0] alt_out = 8'h00;
  logic [7:0] alt_oe = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] ext_en = 8'h00;
  logic irq, adc_trig;
  int failures = 0;
  int n_tests = 0;
  int adc_cnt = 0;
  // ==========================
  // Design and pins
  gpp_port #(.PROT_MASK(8'h80), .ADC_TAP(1'b1)) uut (.core_clk, .rst_n, .addr, .wdata,
    .wr, .rd, .rdata, .pad_in, .pad_out, .pad_oe, .pad_dr2, .pad_dr4, .pad_dr8, .pad_odr,
    .pad_pu, .pad_pd, .pad_slew, .pad_den, .alt_out, .alt_oe, .alt_in, .irq, .adc_trig);
  gpp_pin_model pins_m (.core_clk, .pad_out, .pad_oe, .pad_pu, .pad_pd, .pad_in,
    .ext_val, .ext_en);
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (adc_trig === 1'b1)
      adc_cnt <= adc_cnt + 1;
  // ==========================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [11:0] a, input logic [31:0] exp, input string msg);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp, msg);
  endtask
  task automatic pins(input logic [7:0] v);
    @(posedge core_clk);
    ext_val <= v;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================
  // Scenarios
  task automatic t_defaults();
    chk(pad_oe, 8'h00, "oe");
    chk({pad_pu, pad_den, pad_pd}, {8'h80, 8'h80, 8'h00}, "pulls");
    chk(pad_dr2, 8'hFF, "dr2");
    rreg(OFS_AFSEL, 32'h80, "afsel");
    rreg(OFS_LOCK, 32'h1, "lock");
  endtask
  task automatic t_ident();
    rreg(OFS_ID_LO, ID_WORDS[0], "id0");
    wreg(12'hFFC, 32'h00);
    rreg(12'hFFC, ID_WORDS[11], "id11");
    wreg(12'h600, 32'hFF);
    rreg(12'h600, 32'h0, "unmapped");
  endtask
  task automatic t_data();
    wreg(OFS_DEN, 32'hFF);
    wreg(OFS_DIR, 32'hFF);
    wreg(12'h3FC, 32'h00);
    wreg(12'h098, 32'hEB);
    rreg(12'h3FC, 32'h22, "masked write");
    rreg(12'h0C4, 32'h20, "masked read");
    chk({pad_oe, pad_out}, {8'h7F, 8'h22}, "drive");
  endtask
  task automatic t_input();
    @(posedge core_clk);
    ext_en <= 8'hFF;
    pins(8'hA5);
    wreg(OFS_DIR, 32'h00);
    repeat (2) @(posedge core_clk);
    rreg(12'h1FC, 32'h25, "input");
    chk(alt_in, 8'h80, "alt in");
  endtask
  task automatic t_irq();
    pins(8'h01);
    wreg(OFS_SENSE, 32'h01);
    wreg(OFS_BOTH, 32'h02);
    wreg(OFS_EVENT, 32'h14);
    wreg(OFS_CLEAR, 32'hFF);
    wreg(OFS_MASK, 32'h16);
    rreg(OFS_RAW, 32'h00, "raw idle");
    pins(8'h05);
    chk(irq, 1'b1, "irq edge");
    rreg(OFS_MSTAT, 32'h04, "mstat");
    pins(8'h01);
    pins(8'h05);
    wreg(OFS_CLEAR, 32'h00);
    rreg(OFS_RAW, 32'h04, "latched");
    wreg(OFS_CLEAR, 32'h04);
    @(posedge core_clk);
    #1;
    chk(irq, 1'b0, "irq cleared");
    pins(8'h03);
    rreg(OFS_RAW, 32'h02, "both rise");
    wreg(OFS_CLEAR, 32'h02);
    pins(8'h01);
    rreg(OFS_RAW, 32'h02, "both fall");
    wreg(OFS_CLEAR, 32'h02);
    pins(8'h11);
    chk(adc_cnt, 1, "trigger");
    wreg(OFS_CLEAR, 32'h10);
    pins(8'h10);
    rreg(OFS_RAW, 32'h01, "level");
    chk(irq, 1'b0, "mask gate");
    rreg(OFS_MSTAT, 32'h00, "mstat level");
    wreg(OFS_CLEAR, 32'h01);
    rreg(OFS_RAW, 32'h01, "level hold");
    pins(8'h11);
    rreg(OFS_RAW, 32'h00, "level gone");
  endtask
  task automatic t_lock();
    wreg(OFS_AFSEL, 32'h00);
    rreg(OFS_AFSEL, 32'h80, "locked");
    wreg(OFS_LOCK, LOCK_KEY);
    rreg(OFS_LOCK, 32'h0, "unlock");
    wreg(OFS_AFSEL, 32'h00);
    rreg(OFS_AFSEL, 32'h80, "no commit");
    wreg(OFS_COMMIT, 32'hFF);
    wreg(OFS_AFSEL, 32'h01);
    rreg(OFS_AFSEL, 32'h01, "committed");
    @(posedge core_clk);
    alt_oe <= 8'h01;
    alt_out <= 8'h01;
    repeat (3) @(posedge core_clk);
    #1;
    chk({pad_oe[0], pad_out[0], alt_in[0]}, 3'b111, "alt owns");
  endtask
  task automatic t_pads();
    foreach (PAD_OFS[i])
      wreg(PAD_OFS[i], 32'h3C);
    #1;
    chk({pad_dr2, pad_dr4, pad_dr8}, {3{8'h3C}}, "drive sel");
    chk({pad_odr, pad_pd, pad_slew, pad_pu}, {4{8'h3C}}, "pad sel");
    wreg(OFS_DIR, 32'h0C);
    wreg(12'h020, 32'h08);
    @(posedge core_clk);
    #1;
    chk({pad_oe, pad_out}, {8'h05, 8'h01}, "open drain");
  endtask
  // ==========================
  // Main sequence
  initial
  begin
    do_reset();
    t_defaults();
    t_ident();
    t_data();
    t_input();
    t_irq();
    t_lock();
    t_pads();
    do_reset();
    t_defaults();
    print_verdict();
  end
  initial
  begin
    #20000;
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
